// File: rtl/dtm_consts.svh
// Purpose: Constants of the digital test signal multiplexer
// Assumes: Word-indexed registers on classic Wishbone, byte address = 4 * index
// Notes: Selection codes above 29 drive the pins low
//
// Notes on behaviour
// R1 - Scan enable bit 6 set makes pin 0 the scan-shift-enable input.
// R2 - Bits 5:0 select one group of three signals for pins 0, 1, 2.
// R3 - A pin shows the test signal only when its function selects the mux.
// R4 - Codes 2 and 3 show aux ADC and low-battery detector signals.
// R5 - Codes 0, 1, 4 to 7 show wake-up, clocking and oscillator signals.
// R6 - Codes 8 and 9 show ADC-needed, retransmit, modulation, then pin 0 controls.
// R7 - Codes 10 to 13 show interrupt, serial auxiliary and transmit signals.
// R8 - Codes 14 to 18 show RC-oscillator and VCO calibration signals.
// R9 - Codes 19 to 28 show synthesizer and PLL signals.
// R10 - Code 29 shows the power state, bit 0 on pin 0.
// R11 - Reset clears the select register: scan off, code 0.
// R12 - Mux is combinational on code and signals; bit 7 stored, no effect.
`ifndef DTM_CONSTS_SVH
`define DTM_CONSTS_SVH

`define DTM_SEL_INDEX 8'h51
`define DTM_ROUTE_INDEX 8'h60
`define DTM_STATUS_INDEX 8'h61
`define DTM_SEL_RESET 8'h00
`define DTM_ROUTE_RESET 3'h0
`define DTM_SCAN_BIT 6
`define DTM_RSVD_BIT 7
`define DTM_CODE_MSB 5
`define DTM_CODE_POWER 6'h1d
`define DTM_IDX_MSB 9
`define DTM_IDX_LSB 2
`define DTM_PIN_COUNT 3

`endif

// File: rtl/dtm_pkg.sv
// Purpose: Types of the digital test signal multiplexer
// Assumes: Probe signals arrive from other clock domains
// Notes: Field order must match the probe port order
package dtm_pkg;

    typedef struct packed {
        logic wakeup_slow_clock, first_div_clk, timebase_clk, wake_event, one_sec_tick;
        logic aux_adc_en, aux_adc_ready_n, aux_adc_done, lowbat_cont, lowbat_on, lowbat_raw;
        logic gated_div_clk, mcu_clk, slow_clk_sel, div_en_sync, clkout_en, clkout_en_sync;
        logic osc_en, osc_bias2x, chip_ready, zero_cap, osc_buf_en;
        logic adc_needed, ext_retx_req, tx_mod_pin, pin0_analog_sel, pin0_adc_line_en;
        logic int_ack1, int_ack2, int_latch, ext_int_pin2, ext_status_all, masked_int_all;
        logic serout_aux_sel, serout_aux, irq_aux_sel, txdata_on_serin, tx_mod, tx_clk_out;
        logic rc_full_start, rc_fine_start, xtal_req, rc_coarse_ready, rc_fine_ready, xtal_req_sync;
        logic vco_cal_rst_n, vco_cal_run, vco_cal_done, vco_cal_en, ref_cnt_en, freq_cnt_en, pos_diff;
        logic sigma_clk, pll_fb_clk, pll_ref_clk;
        logic [3:0] sigma_bits;
        logic fbdiv15, sigma_rst_n;
        logic pll_en, pll_initial_settled, pll_soft_settled, freq_change_req, vco_bias_shunt_en;
        logic freq_recalc_req, bandgap_en, frac_div_en, buffer3_en;
        logic pfd_up, pfd_down, pfd_change, pll_lock;
        logic [2:0] power_state;
    } dtm_probe_t;

endpackage

// File: rtl/dtm_sync.sv
// Purpose: Two-flop synchroniser for a vector of levels
// Assumes: Each bit is an independent slow level
// Notes: Clocks probed here are only seen at up to half the sample rate
`timescale 1ns/10ps
`default_nettype none
module dtm_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: rtl/dtm_top.sv
// Purpose: Digital test signal multiplexer onto three general pins
// Assumes: Probe inputs and pin 0 input are asynchronous to sys_clk
// Notes: Pin outputs lag the selected probe by three clocks
`timescale 1ns/10ps
`default_nettype none
`include "dtm_consts.svh"
module dtm_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Normal pin function
    input wire logic [2:0] user_pin_out,
    input wire logic [2:0] user_pin_oe_n,
    // General pins
    input wire logic general_pin_0_in,
    output logic general_pin_0_out,
    output logic general_pin_0_oe_n,
    output logic general_pin_1_out,
    output logic general_pin_1_oe_n,
    output logic general_pin_2_out,
    output logic general_pin_2_oe_n,
    output logic scan_shift_enable,
    // Wake-up and timebase probes
    input wire logic wakeup_slow_clock,
    input wire logic first_div_clk,
    input wire logic timebase_clk,
    input wire logic wake_event,
    input wire logic one_sec_tick,
    // Aux ADC and battery probes
    input wire logic aux_adc_en,
    input wire logic aux_adc_ready_n,
    input wire logic aux_adc_done,
    input wire logic lowbat_cont,
    input wire logic lowbat_on,
    input wire logic lowbat_raw,
    // Clocking and oscillator probes
    input wire logic gated_div_clk,
    input wire logic mcu_clk,
    input wire logic slow_clk_sel,
    input wire logic div_en_sync,
    input wire logic clkout_en,
    input wire logic clkout_en_sync,
    input wire logic osc_en,
    input wire logic osc_bias2x,
    input wire logic chip_ready,
    input wire logic zero_cap,
    input wire logic osc_buf_en,
    // Transmit input and pin 0 probes
    input wire logic adc_needed,
    input wire logic ext_retx_req,
    input wire logic tx_mod_pin,
    input wire logic pin0_analog_sel,
    input wire logic pin0_adc_line_en,
    // Interrupt and serial probes
    input wire logic int_ack1,
    input wire logic int_ack2,
    input wire logic int_latch,
    input wire logic ext_int_pin2,
    input wire logic ext_status_all,
    input wire logic masked_int_all,
    input wire logic serout_aux_sel,
    input wire logic serout_aux,
    input wire logic irq_aux_sel,
    input wire logic txdata_on_serin,
    input wire logic tx_mod,
    input wire logic tx_clk_out,
    // Calibration probes
    input wire logic rc_full_start,
    input wire logic rc_fine_start,
    input wire logic xtal_req,
    input wire logic rc_coarse_ready,
    input wire logic rc_fine_ready,
    input wire logic xtal_req_sync,
    input wire logic vco_cal_rst_n,
    input wire logic vco_cal_run,
    input wire logic vco_cal_done,
    input wire logic vco_cal_en,
    input wire logic ref_cnt_en,
    input wire logic freq_cnt_en,
    input wire logic pos_diff,
    // Synthesizer probes
    input wire logic sigma_clk,
    input wire logic pll_fb_clk,
    input wire logic pll_ref_clk,
    input wire logic [3:0] sigma_bits,
    input wire logic fbdiv15,
    input wire logic sigma_rst_n,
    input wire logic pll_en,
    input wire logic pll_initial_settled,
    input wire logic pll_soft_settled,
    input wire logic freq_change_req,
    input wire logic vco_bias_shunt_en,
    input wire logic freq_recalc_req,
    input wire logic bandgap_en,
    input wire logic frac_div_en,
    input wire logic buffer3_en,
    input wire logic pfd_up,
    input wire logic pfd_down,
    input wire logic pfd_change,
    input wire logic pll_lock,
    // Power state probe
    input wire logic [2:0] power_state
);
    import dtm_pkg::*;

    dtm_probe_t probe_raw;
    dtm_probe_t probe;
    logic [7:0] test_signal_select;
    logic [2:0] route_enable;
    logic [4:0] status_word;
    logic pin0_level;
    logic wr_sel;
    logic wr_route;
    logic scan_on;
    logic [2:0] mux_out;
    logic [2:0] next_pin_out;
    logic [2:0] next_pin_oe_n;

    assign probe_raw = {
        wakeup_slow_clock,
        first_div_clk,
        timebase_clk,
        wake_event,
        one_sec_tick,
        aux_adc_en,
        aux_adc_ready_n,
        aux_adc_done,
        lowbat_cont,
        lowbat_on,
        lowbat_raw,
        gated_div_clk,
        mcu_clk,
        slow_clk_sel,
        div_en_sync,
        clkout_en,
        clkout_en_sync,
        osc_en,
        osc_bias2x,
        chip_ready,
        zero_cap,
        osc_buf_en,
        adc_needed,
        ext_retx_req,
        tx_mod_pin,
        pin0_analog_sel,
        pin0_adc_line_en,
        int_ack1,
        int_ack2,
        int_latch,
        ext_int_pin2,
        ext_status_all,
        masked_int_all,
        serout_aux_sel,
        serout_aux,
        irq_aux_sel,
        txdata_on_serin,
        tx_mod,
        tx_clk_out,
        rc_full_start,
        rc_fine_start,
        xtal_req,
        rc_coarse_ready,
        rc_fine_ready,
        xtal_req_sync,
        vco_cal_rst_n,
        vco_cal_run,
        vco_cal_done,
        vco_cal_en,
        ref_cnt_en,
        freq_cnt_en,
        pos_diff,
        sigma_clk,
        pll_fb_clk,
        pll_ref_clk,
        sigma_bits,
        fbdiv15,
        sigma_rst_n,
        pll_en,
        pll_initial_settled,
        pll_soft_settled,
        freq_change_req,
        vco_bias_shunt_en,
        freq_recalc_req,
        bandgap_en,
        frac_div_en,
        buffer3_en,
        pfd_up,
        pfd_down,
        pfd_change,
        pll_lock,
        power_state
    };

    dtm_sync #(.WIDTH($bits(dtm_probe_t))) u_probe_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(probe_raw),
        .sync_out(probe)
    );

    dtm_sync #(.WIDTH(1)) u_pin0_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(general_pin_0_in),
        .sync_out(pin0_level)
    );

    dtm_wb_port u_wb (
        .sys_clk(sys_clk),
        .reset(reset),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .sel_word(test_signal_select),
        .route_word(route_enable),
        .status_word(status_word),
        .wr_sel(wr_sel),
        .wr_route(wr_route)
    );

    // Bit 7 is kept for read-back only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            test_signal_select <= `DTM_SEL_RESET; // R11
        end else if (wr_sel) begin
            test_signal_select <= wb_dat_i[7:0]; // R12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            route_enable <= `DTM_ROUTE_RESET;
        end else if (wr_route) begin
            route_enable <= wb_dat_i[`DTM_PIN_COUNT-1:0];
        end
    end

    assign scan_on = test_signal_select[`DTM_SCAN_BIT];
    assign status_word = {general_pin_2_out, general_pin_1_out, general_pin_0_out, scan_shift_enable, pin0_level};

    // Pure decode; bits are {pin 2, pin 1, pin 0}
    function automatic logic [2:0] dtm_route(input logic [5:0] code, input dtm_probe_t p, input logic own_oe_n);
        logic [2:0] r;
        r = 3'h0;
        case (code)
            6'h00: r = {p.timebase_clk, p.first_div_clk, p.wakeup_slow_clock}; // R5
            6'h01: r = {p.one_sec_tick, p.wake_event, p.wakeup_slow_clock}; // R5
            6'h02: r = {p.aux_adc_done, p.aux_adc_ready_n, p.aux_adc_en}; // R4
            6'h03: r = {p.lowbat_raw, p.lowbat_on, p.lowbat_cont}; // R4
            6'h04: r = {p.slow_clk_sel, p.mcu_clk, p.gated_div_clk}; // R5
            6'h05: r = {p.clkout_en_sync, p.clkout_en, p.div_en_sync}; // R5
            6'h06: r = {p.chip_ready, p.osc_bias2x, p.osc_en}; // R5
            6'h07: r = {p.osc_buf_en, p.zero_cap, p.chip_ready}; // R5
            6'h08: r = {p.tx_mod_pin, p.ext_retx_req, p.adc_needed}; // R6
            6'h09: r = {p.pin0_adc_line_en, p.pin0_analog_sel, own_oe_n}; // R6
            6'h0a: r = {p.int_latch, p.int_ack2, p.int_ack1}; // R7
            6'h0b: r = {p.masked_int_all, p.ext_status_all, p.ext_int_pin2}; // R7
            6'h0c: r = {p.irq_aux_sel, p.serout_aux, p.serout_aux_sel}; // R7
            6'h0d: r = {p.tx_clk_out, p.tx_mod, p.txdata_on_serin}; // R7
            6'h0e: r = {p.xtal_req, p.rc_fine_start, p.rc_full_start}; // R8
            6'h0f: r = {p.xtal_req_sync, p.rc_fine_ready, p.rc_coarse_ready}; // R8
            6'h10: r = {p.vco_cal_done, p.vco_cal_run, p.vco_cal_rst_n}; // R8
            6'h11: r = {p.freq_cnt_en, p.ref_cnt_en, p.vco_cal_en}; // R8
            6'h12: r = {p.freq_cnt_en, p.pos_diff, p.vco_cal_en}; // R8
            6'h13: r = {p.pll_ref_clk, p.pll_fb_clk, p.sigma_clk}; // R9
            6'h14: r = p.sigma_bits[2:0]; // R9
            6'h15: r = {p.sigma_rst_n, p.fbdiv15, p.sigma_bits[3]}; // R9
            6'h16: r = {p.pll_soft_settled, p.pll_initial_settled, p.pll_en}; // R9
            6'h17: r = {p.vco_cal_done, p.pll_soft_settled, p.freq_change_req}; // R9
            6'h18: r = {p.freq_recalc_req, p.vco_bias_shunt_en, p.vco_cal_en}; // R9
            6'h19: r = {p.buffer3_en, p.frac_div_en, p.bandgap_en}; // R9
            6'h1a: r = {p.pfd_change, p.pfd_down, p.pfd_up}; // R9
            6'h1b: r = {p.pll_initial_settled, p.pll_en, p.pll_lock}; // R9
            6'h1c: r = {p.pll_soft_settled, p.pll_lock, p.pll_en}; // R9
            `DTM_CODE_POWER: r = p.power_state; // R10
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    assign mux_out = dtm_route(test_signal_select[`DTM_CODE_MSB:0], probe, general_pin_0_oe_n); // R2 R12

    always_comb begin
        for (int i = 0; i < `DTM_PIN_COUNT; i++) begin
            next_pin_out[i] = route_enable[i] ? mux_out[i] : user_pin_out[i]; // R3
            next_pin_oe_n[i] = route_enable[i] ? 1'b0 : user_pin_oe_n[i]; // R3
        end
        // Pin 0 turns into an input while scan test runs
        if (scan_on) begin
            next_pin_out[0] = 1'b0; // R1
            next_pin_oe_n[0] = 1'b1; // R1
        end
    end

    // Registered outputs avoid glitches from the decode on the pads
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            general_pin_0_out <= 1'b0;
            general_pin_1_out <= 1'b0;
            general_pin_2_out <= 1'b0;
            general_pin_0_oe_n <= 1'b1;
            general_pin_1_oe_n <= 1'b1;
            general_pin_2_oe_n <= 1'b1;
        end else begin
            general_pin_0_out <= next_pin_out[0];
            general_pin_1_out <= next_pin_out[1];
            general_pin_2_out <= next_pin_out[2];
            general_pin_0_oe_n <= next_pin_oe_n[0];
            general_pin_1_oe_n <= next_pin_oe_n[1];
            general_pin_2_oe_n <= next_pin_oe_n[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            scan_shift_enable <= 1'b0;
        end else begin
            scan_shift_enable <= scan_on & pin0_level; // R1
        end
    end

    default clocking dtm_cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sel_reset_a: assert property ($past(reset) |-> test_signal_select == `DTM_SEL_RESET) // R11
        else $error("select register not clear after reset");
    scan_release_a: assert property (scan_on |=> general_pin_0_oe_n) // R1
        else $error("pin 0 still driven in scan test");
    scan_input_a: assert property (scan_on && pin0_level |=> scan_shift_enable) // R1
        else $error("scan shift enable does not follow pin 0");
    scan_off_a: assert property (!scan_on |=> !scan_shift_enable) // R1
        else $error("scan shift enable high while scan test is off");
    route_off_a: assert property (!route_enable[1] && !scan_on |=> general_pin_1_out == $past(user_pin_out[1])) // R3
        else $error("pin 1 shows test signal while not routed");
    code_zero_a: assert property (route_enable == 3'h7 && !scan_on && test_signal_select[5:0] == 6'h00
        |=> general_pin_2_out == $past(probe.timebase_clk) && general_pin_0_out == $past(probe.wakeup_slow_clock)) // R5
        else $error("code 0 group wrong on pins");
    code_adc_a: assert property (route_enable == 3'h7 && !scan_on && test_signal_select[5:0] == 6'h02
        |=> general_pin_1_out == $past(probe.aux_adc_ready_n)) // R4
        else $error("code 2 group wrong on pins");
    code_power_a: assert property (route_enable == 3'h7 && !scan_on && test_signal_select[5:0] == 6'h1d
        |=> {general_pin_2_out, general_pin_1_out, general_pin_0_out} == $past(probe.power_state)) // R10
        else $error("power state not on pins for code 29");
    code_pll_a: assert property (route_enable[2] && test_signal_select[5:0] == 6'h1a
        |=> general_pin_2_out == $past(probe.pfd_change)) // R9
        else $error("code 26 pin 2 wrong");
    reserved_keep_a: assert property (wr_sel |=> test_signal_select[`DTM_RSVD_BIT] == $past(wb_dat_i[7])) // R12
        else $error("reserved bit not stored");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    scan_used_c: cover property (scan_on ##1 scan_shift_enable);
    power_shown_c: cover property (route_enable == 3'h7 && test_signal_select[5:0] == `DTM_CODE_POWER);
    sel_write_c: cover property (wr_sel ##2 wb_cyc_i && wb_stb_i && !wb_we_i);
endmodule
`default_nettype wire

// File: rtl/dtm_wb_port.sv
// Purpose: Classic Wishbone slave port with word-indexed registers
// Assumes: Master holds its request until it samples ack
// Notes: Ack one cycle after request, for one cycle; unmapped reads return zero
`timescale 1ns/10ps
`default_nettype none
`include "dtm_consts.svh"
module dtm_wb_port (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Register file
    input wire logic [7:0] sel_word,
    input wire logic [2:0] route_word,
    input wire logic [4:0] status_word,
    output logic wr_sel,
    output logic wr_route
);
    logic req;
    logic hit_high;
    logic [7:0] idx;
    logic commit;

    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[`DTM_IDX_MSB:`DTM_IDX_LSB];
    assign hit_high = (wb_adr_i[31:`DTM_IDX_MSB+1] == '0);
    // Writes land at the edge where the master sees ack
    assign commit = req & wb_ack_o & wb_we_i & wb_sel_i[0] & hit_high;
    assign wr_sel = commit & (idx == `DTM_SEL_INDEX);
    assign wr_route = commit & (idx == `DTM_ROUTE_INDEX);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wb_dat_o <= '0;
        end else if (req & ~wb_ack_o & ~hit_high) begin
            wb_dat_o <= '0;
        end else if (req & ~wb_ack_o) begin
            case (idx)
                `DTM_SEL_INDEX: wb_dat_o <= {24'h000000, sel_word};
                `DTM_ROUTE_INDEX: wb_dat_o <= {29'h0, route_word};
                `DTM_STATUS_INDEX: wb_dat_o <= {27'h0, status_word};
                default: wb_dat_o <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: verif/dtm_scope.sv
// Purpose: Test equipment model on the three general pins
// Assumes: Equipment drives pin 0 only while the block releases it
// Notes: Released pins 1 and 2 read back inverted so a stale level never matches; released pin 0 reads the scan level
`timescale 1ns/10ps
`default_nettype none
module dtm_scope (
    // Block side
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    // Equipment side
    input wire logic scan_lvl,
    output logic [2:0] seen,
    output logic pin0_in
);
    assign pin0_in = pin_oe_n[0] ? scan_lvl : pin_out[0];
    assign seen = {pin_out[2:1] ^ pin_oe_n[2:1], pin0_in};
endmodule
`default_nettype wire

// File: verif/tb_digital_test_signal_mux.sv
// Purpose: Self-checking bench for the test signal multiplexer
// Assumes: Probes held still while a pin check settles
// Notes: Pins lag probes by three clocks, checks wait five
`timescale 1ns/10ps
`default_nettype none
`include "dtm_consts.svh"
module tb_digital_test_signal_mux;
    logic sys_clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, lvl = 0, wb_ack_o, scan_shift_enable;
    logic general_pin_0_in, general_pin_0_out, general_pin_0_oe_n, general_pin_1_out, general_pin_1_oe_n;
    logic general_pin_2_out, general_pin_2_oe_n;
    logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o;
    logic [3:0] wb_sel_i = 4'hf, sigma_bits;
    logic [2:0] user_pin_out = 0, user_pin_oe_n = 3'h7, power_state, seen;
    logic [7:0] q[$];
    int fails = 0, num_checks = 0, seed = 62;
    event smp;
    logic wakeup_slow_clock,first_div_clk,timebase_clk,wake_event,one_sec_tick,aux_adc_en,aux_adc_ready_n;
    logic aux_adc_done,lowbat_cont,lowbat_on,lowbat_raw,gated_div_clk,mcu_clk,slow_clk_sel,div_en_sync,clkout_en;
    logic clkout_en_sync,osc_en,osc_bias2x,chip_ready,zero_cap,osc_buf_en,adc_needed,ext_retx_req,tx_mod_pin;
    logic pin0_analog_sel,pin0_adc_line_en,int_ack1,int_ack2,int_latch,ext_int_pin2,ext_status_all,masked_int_all;
    logic serout_aux_sel,serout_aux,irq_aux_sel,txdata_on_serin,tx_mod,tx_clk_out,rc_full_start,rc_fine_start;
    logic xtal_req,rc_coarse_ready,rc_fine_ready,xtal_req_sync,vco_cal_rst_n,vco_cal_run,vco_cal_done,vco_cal_en;
    logic ref_cnt_en,freq_cnt_en,pos_diff,sigma_clk,pll_fb_clk,pll_ref_clk,fbdiv15,sigma_rst_n,pll_en;
    logic pll_initial_settled,pll_soft_settled,freq_change_req,vco_bias_shunt_en,freq_recalc_req,bandgap_en;
    logic frac_div_en,buffer3_en,pfd_up,pfd_down,pfd_change,pll_lock;
    dtm_top DUT (.*);
    dtm_scope eq (.pin_out({general_pin_2_out, general_pin_1_out, general_pin_0_out}), .scan_lvl(lvl),
        .pin_oe_n({general_pin_2_oe_n, general_pin_1_oe_n, general_pin_0_oe_n}), .seen(seen), .pin0_in(general_pin_0_in));
    initial forever #4 sys_clk = ~sys_clk;
    initial begin
        #100000;
        fails++;
        end_sim;
    end
    task automatic stir;
        {wakeup_slow_clock,first_div_clk,timebase_clk,wake_event,one_sec_tick,aux_adc_en,aux_adc_ready_n,
        aux_adc_done,lowbat_cont,lowbat_on,lowbat_raw,gated_div_clk,mcu_clk,slow_clk_sel,div_en_sync,clkout_en,
        clkout_en_sync,osc_en,osc_bias2x,chip_ready,zero_cap,osc_buf_en,adc_needed,ext_retx_req,tx_mod_pin,
        pin0_analog_sel,pin0_adc_line_en,int_ack1,int_ack2,int_latch,ext_int_pin2,ext_status_all,masked_int_all,
        serout_aux_sel,serout_aux,irq_aux_sel,txdata_on_serin,tx_mod,tx_clk_out,rc_full_start,rc_fine_start,
        xtal_req,rc_coarse_ready,rc_fine_ready,xtal_req_sync,vco_cal_rst_n,vco_cal_run,vco_cal_done,vco_cal_en,
        ref_cnt_en,freq_cnt_en,pos_diff,sigma_clk,pll_fb_clk,pll_ref_clk,fbdiv15,sigma_rst_n,pll_en,
        pll_initial_settled,pll_soft_settled,freq_change_req,vco_bias_shunt_en,freq_recalc_req,bandgap_en,
        frac_div_en,buffer3_en,pfd_up,pfd_down,pfd_change,pll_lock,sigma_bits,power_state}
            <= 77'({$random(seed), $random(seed), $random(seed)});
    endtask
    function automatic logic [2:0] pick(input logic [5:0] c);
        case (c)
            0: return {timebase_clk,first_div_clk,wakeup_slow_clock};
            1: return {one_sec_tick,wake_event,wakeup_slow_clock};
            2: return {aux_adc_done,aux_adc_ready_n,aux_adc_en};
            3: return {lowbat_raw,lowbat_on,lowbat_cont};
            4: return {slow_clk_sel,mcu_clk,gated_div_clk};
            5: return {clkout_en_sync,clkout_en,div_en_sync};
            6: return {chip_ready,osc_bias2x,osc_en};
            7: return {osc_buf_en,zero_cap,chip_ready};
            8: return {tx_mod_pin,ext_retx_req,adc_needed};
            9: return {pin0_adc_line_en,pin0_analog_sel,1'b0};
            10: return {int_latch,int_ack2,int_ack1};
            11: return {masked_int_all,ext_status_all,ext_int_pin2};
            12: return {irq_aux_sel,serout_aux,serout_aux_sel};
            13: return {tx_clk_out,tx_mod,txdata_on_serin};
            14: return {xtal_req,rc_fine_start,rc_full_start};
            15: return {xtal_req_sync,rc_fine_ready,rc_coarse_ready};
            16: return {vco_cal_done,vco_cal_run,vco_cal_rst_n};
            17: return {freq_cnt_en,ref_cnt_en,vco_cal_en};
            18: return {freq_cnt_en,pos_diff,vco_cal_en};
            19: return {pll_ref_clk,pll_fb_clk,sigma_clk};
            20: return sigma_bits[2:0];
            21: return {sigma_rst_n,fbdiv15,sigma_bits[3]};
            22: return {pll_soft_settled,pll_initial_settled,pll_en};
            23: return {vco_cal_done,pll_soft_settled,freq_change_req};
            24: return {freq_recalc_req,vco_bias_shunt_en,vco_cal_en};
            25: return {buffer3_en,frac_div_en,bandgap_en};
            26: return {pfd_change,pfd_down,pfd_up};
            27: return {pll_initial_settled,pll_en,pll_lock};
            28: return {pll_soft_settled,pll_lock,pll_en};
            29: return power_state;
            default: return 3'h0;
        endcase
    endfunction
    task automatic cmp(input string nm, input logic [7:0] v);
        logic [7:0] e;
        e = q.pop_front();
        num_checks++;
        if (v !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask
    always @(negedge sys_clk) if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) cmp("read data", wb_dat_o[7:0]);
    always @(smp) cmp("pins", {4'h0, scan_shift_enable, seen});
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {22'h0, idx, 2'h0};
        wb_dat_i <= {24'h0, d};
        do
            @(posedge sys_clk);
        while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        q.push_back(e);
        bus(1'b0, idx, 8'h00);
    endtask
    task automatic look(input logic [7:0] e);
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        q.push_back(e);
        -> smp;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        stir;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`DTM_SEL_INDEX, `DTM_SEL_RESET);
        rd(8'h7f, 8'h00);
        bus(1'b1, `DTM_ROUTE_INDEX, 8'h07);
        for (int c = 0; c < 32; c++) begin
            bus(1'b1, `DTM_SEL_INDEX, 8'(c));
            stir;
            @(posedge sys_clk);
            look({5'h0, pick(6'(c))});
        end
        $display("test codes done");
        bus(1'b1, `DTM_SEL_INDEX, 8'hbf);
        rd(`DTM_SEL_INDEX, 8'hbf);
        look(8'h00);
        bus(1'b1, `DTM_SEL_INDEX, 8'h9d);
        bus(1'b1, `DTM_ROUTE_INDEX, 8'h02);
        user_pin_out <= 3'($random(seed));
        user_pin_oe_n <= 3'h0;
        @(posedge sys_clk);
        look({5'h0, user_pin_out[2], power_state[1], user_pin_out[0]});
        $display("test routing done");
        bus(1'b1, `DTM_SEL_INDEX, 8'h40);
        repeat (2) begin
            @(posedge sys_clk);
            lvl <= !lvl;
            @(posedge sys_clk);
            look({4'h0, lvl, user_pin_out[2], first_div_clk, lvl});
        end
        rd(`DTM_STATUS_INDEX, {3'h0, user_pin_out[2], first_div_clk, 1'b0, lvl, lvl});
        rd(`DTM_ROUTE_INDEX, 8'h02);
        wb_sel_i <= 4'he;
        bus(1'b1, `DTM_SEL_INDEX, 8'h00);
        wb_sel_i <= 4'hf;
        rd(`DTM_SEL_INDEX, 8'h40);
        $display("test scan done");
        end_sim;
    end
endmodule
`default_nettype wire
